// File: common/dmac_pkg.sv
// constants, types and decode patterns of the dual long-operand mac datapath
// Function
// RQ1 - two macs run in one cycle: high words in unit two, low words in unit one
// RQ2 - op word pattern 0101 01mm selects both products onto unshifted accumulators
// RQ3 - op word pattern 0110 00mm selects unshifted acc_y and right-shifted acc_x
// RQ4 - high data word at effective address on long_read_bus_c, extended to 17 bits
// RQ5 - high coefficient word at effective address on coef_bus_high to unit two
// RQ6 - low words come from partner address: plus one if even, minus one if odd
// RQ7 - low data on read_bus_d, low coefficient on coef_bus_low, extended to 17 bits
// RQ8 - unsigned keyword zero-extends that memory word to 17 bits
// RQ9 - fractional_mode set shifts each product left by one bit
// RQ10 - multiply_saturation_mode governs product overflow saturation
// RQ11 - 32-bit product sign-extended to 40 bits and added to its accumulator
// RQ12 - mixed form shifts acc_x right 16 with bit 39 replicated
// RQ13 - round keyword rounds each result as rounding_mode_select says
// RQ14 - overflow per wide_overflow_mode sets the destination overflow flag
// RQ15 - overflowed result saturates when datapath_saturation_enable is set
// RQ16 - wide keyword forces wide overflow mode for one instruction only
// RQ17 - software keeps coefficient operands out of external memory
// RQ18 - instructions may repeat back to back
// RQ19 - long data pointer post-decrement steps by two
// RQ20 - coefficient pointer post-increment steps by two
// RQ21 - single-word form post-decrements the data pointer by one
// RQ22 - single-word both-shifted form shifts acc_y right 16 before adding
// RQ23 - overflow checked at bit 31 or bit 39, each flag kept on its own
package dmac_pkg;
  localparam logic [5:0] DMAC_PAT_LONG_UNSH = 6'h15;
  localparam logic [5:0] DMAC_PAT_LONG_MIX = 6'h18;
  localparam logic [5:0] DMAC_PAT_LONG_BOTH = 6'h1b;
  localparam logic [5:0] DMAC_PAT_SHORT_MIX = 6'h08;
  localparam logic [5:0] DMAC_PAT_SHORT_BOTH = 6'h0b;
  localparam logic [7:0] DMAC_REG_CTRL = 8'h00;
  localparam logic [7:0] DMAC_REG_STAT = 8'h04;
  localparam logic [7:0] DMAC_REG_ACCX_LO = 8'h08;
  localparam logic [7:0] DMAC_REG_ACCX_HI = 8'h0c;
  localparam logic [7:0] DMAC_REG_ACCY_LO = 8'h10;
  localparam logic [7:0] DMAC_REG_ACCY_HI = 8'h14;
  localparam logic [7:0] DMAC_REG_PTR_DATA = 8'h18;
  localparam logic [7:0] DMAC_REG_PTR_COEF = 8'h1c;
  localparam int DMAC_STAT_FLAG_X = 0;
  localparam int DMAC_STAT_FLAG_Y = 1;
  localparam logic [15:0] DMAC_STEP_LONG = 16'h0002;
  localparam logic [15:0] DMAC_STEP_SHORT = 16'h0001;
  localparam logic [15:0] DMAC_STEP_COEF = 16'h0002;
  localparam logic [16:0] DMAC_MIN17 = 17'h18000;
  localparam logic [31:0] DMAC_PROD_SAT = 32'h7fffffff;
  localparam logic [40:0] DMAC_RND_ADD = 41'h000_0000_8000;
  localparam logic [15:0] DMAC_RND_HALF = 16'h8000;
  localparam logic [39:0] DMAC_SAT40_POS = 40'h7fffffffff;
  localparam logic [39:0] DMAC_SAT40_NEG = 40'h8000000000;
  localparam logic [39:0] DMAC_SAT32_POS = 40'h007fffffff;
  localparam logic [39:0] DMAC_SAT32_NEG = 40'hff80000000;
  localparam logic [39:0] DMAC_ACC_RST = 40'h0000000000;
  localparam logic [15:0] DMAC_PTR_RST = 16'h0000;
  typedef enum {
    DMAC_V_NONE, DMAC_V_LONG_UNSH, DMAC_V_LONG_MIX, DMAC_V_LONG_BOTH,
    DMAC_V_SHORT_MIX, DMAC_V_SHORT_BOTH
  } dmac_variant_t;
  typedef struct packed {
    logic [15:0] op_word;
    logic uns_mem;
    logic uns_coef;
    logic rnd;
    logic wide_kw;
    logic data_post_dec;
    logic coef_post_inc;
  } dmac_instr_t;
  typedef struct packed {
    logic fractional_mode;
    logic multiply_saturation_mode;
    logic wide_overflow_mode;
    logic rounding_mode_select;
    logic datapath_saturation_enable;
  } dmac_ctrl_t;
  typedef struct packed {
    logic [15:0] x_hi;
    logic [15:0] x_lo;
    logic [15:0] c_hi;
    logic [15:0] c_lo;
  } dmac_addr_t;
  typedef struct packed {
    logic [39:0] acc;
    logic ovf;
  } dmac_lane_t;
endpackage

// File: logic/dmac_core.sv
// dual multiply-accumulate datapath with long memory and long coefficient operands
`timescale 1ns/1ps
`default_nettype none
module dmac_core
  import dmac_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // instruction issue
  input wire logic instr_valid,
  input wire dmac_instr_t instr,
  output logic instr_done,
  // memory side
  output logic mem_rd,
  output dmac_addr_t mem_addr,
  input wire logic [15:0] long_read_bus_c,
  input wire logic [15:0] read_bus_d,
  input wire logic [15:0] coef_bus_high,
  input wire logic [15:0] coef_bus_low,
  // status
  output logic acc_overflow_flag_x,
  output logic acc_overflow_flag_y
);

  function automatic logic [16:0] ext17(input logic [15:0] w, input logic uns);
    ext17 = {(uns ? 1'b0 : w[15]), w};
  endfunction

  function automatic logic [15:0] partner(input logic [15:0] a);
    partner = a[0] ? a - 16'h0001 : a + 16'h0001;
  endfunction

  function automatic dmac_variant_t decode(input logic [15:0] op);
    decode = DMAC_V_NONE;
    if (op[15:10] == DMAC_PAT_LONG_UNSH) begin
      decode = DMAC_V_LONG_UNSH;
    end else if (op[15:10] == DMAC_PAT_LONG_MIX) begin
      decode = DMAC_V_LONG_MIX;
    end else if (op[15:10] == DMAC_PAT_LONG_BOTH) begin
      decode = DMAC_V_LONG_BOTH;
    end else if (op[15:10] == DMAC_PAT_SHORT_MIX) begin
      decode = DMAC_V_SHORT_MIX;
    end else if (op[15:10] == DMAC_PAT_SHORT_BOTH) begin
      decode = DMAC_V_SHORT_BOTH;
    end
  endfunction

  function automatic dmac_lane_t mac_lane(
    input logic [39:0] acc,
    input logic pre_sh,
    input logic [16:0] a,
    input logic [16:0] b,
    input dmac_ctrl_t c,
    input logic rnd,
    input logic m40
  );
    logic signed [33:0] p;
    logic [31:0] p32;
    logic [39:0] src;
    logic [40:0] sum;
    logic [15:0] low;
    dmac_lane_t r;
    p = $signed(a) * $signed(b);
    // RQ9 fractional product shift
    p32 = c.fractional_mode ? {p[30:0], 1'b0} : p[31:0];
    // RQ10 product saturation mode
    if (c.multiply_saturation_mode && c.fractional_mode &&
        a == DMAC_MIN17 && b == DMAC_MIN17) begin
      p32 = DMAC_PROD_SAT;
    end
    // RQ22 accumulator pre-shift
    src = pre_sh ? {{16{acc[39]}}, acc[39:16]} : acc;
    // RQ11 extend and accumulate
    sum = {src[39], src} + {{9{p32[31]}}, p32};
    low = sum[15:0];
    // RQ13 rounding by mode
    if (rnd) begin
      sum = sum + DMAC_RND_ADD;
      if (c.rounding_mode_select && low == DMAC_RND_HALF) begin
        sum[16] = 1'b0;
      end
      sum[15:0] = 16'h0000;
    end
    // RQ23 overflow at bit 31 or 39
    r.ovf = m40 ? (sum[40] != sum[39]) : !((&sum[40:31]) || !(|sum[40:31]));
    r.acc = sum[39:0];
    // saturation on overflow
    if (r.ovf && c.datapath_saturation_enable) begin
      if (m40) begin
        r.acc = sum[40] ? DMAC_SAT40_NEG : DMAC_SAT40_POS;
      end else begin
        r.acc = sum[40] ? DMAC_SAT32_NEG : DMAC_SAT32_POS;
      end
    end
    mac_lane = r;
  endfunction

  dmac_ctrl_t ctrl_r;
  logic [39:0] acc_x_r;
  logic [39:0] acc_y_r;
  logic [15:0] ptr_data_r;
  logic [15:0] ptr_coef_r;
  logic flag_x_r;
  logic flag_y_r;
  logic mem_rd_r;
  logic done_r;
  dmac_addr_t addr_r;
  dmac_instr_t s_instr_r;
  dmac_variant_t s_var_r;
  logic [31:0] rdata_r;

  // issue decode
  dmac_variant_t issue_var;
  assign issue_var = decode(instr.op_word);
  wire issue_go = instr_valid && issue_var != DMAC_V_NONE;
  wire issue_long = issue_var == DMAC_V_LONG_UNSH || issue_var == DMAC_V_LONG_MIX ||
                    issue_var == DMAC_V_LONG_BOTH;

  // register decode
  wire sel_ctrl = reg_addr == DMAC_REG_CTRL;
  wire sel_stat = reg_addr == DMAC_REG_STAT;
  wire sel_ax_lo = reg_addr == DMAC_REG_ACCX_LO;
  wire sel_ax_hi = reg_addr == DMAC_REG_ACCX_HI;
  wire sel_ay_lo = reg_addr == DMAC_REG_ACCY_LO;
  wire sel_ay_hi = reg_addr == DMAC_REG_ACCY_HI;
  wire sel_pd = reg_addr == DMAC_REG_PTR_DATA;
  wire sel_pc = reg_addr == DMAC_REG_PTR_COEF;
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (sel_ctrl) begin
      rd_mux = {27'h0, ctrl_r};
    end else if (sel_stat) begin
      rd_mux = {30'h0, flag_y_r, flag_x_r};
    end else if (sel_ax_lo) begin
      rd_mux = acc_x_r[31:0];
    end else if (sel_ax_hi) begin
      rd_mux = {24'h000000, acc_x_r[39:32]};
    end else if (sel_ay_lo) begin
      rd_mux = acc_y_r[31:0];
    end else if (sel_ay_hi) begin
      rd_mux = {24'h000000, acc_y_r[39:32]};
    end else if (sel_pd) begin
      rd_mux = {16'h0000, ptr_data_r};
    end else if (sel_pc) begin
      rd_mux = {16'h0000, ptr_coef_r};
    end
  end

  // operand selection in the execute cycle
  wire s_long = s_var_r == DMAC_V_LONG_UNSH || s_var_r == DMAC_V_LONG_MIX ||
                s_var_r == DMAC_V_LONG_BOTH;
  // RQ5 RQ7 operand buses; single word is shared by both units
  wire [15:0] hi_word = s_long ? long_read_bus_c : read_bus_d;
  // RQ8 unsigned zero extension
  wire [16:0] a_hi = ext17(hi_word, s_instr_r.uns_mem);
  wire [16:0] b_hi = ext17(coef_bus_high, s_instr_r.uns_coef);
  wire [16:0] a_lo = ext17(read_bus_d, s_instr_r.uns_mem);
  wire [16:0] b_lo = ext17(coef_bus_low, s_instr_r.uns_coef);
  wire shift_y = s_var_r == DMAC_V_LONG_BOTH || s_var_r == DMAC_V_SHORT_BOTH;
  wire shift_x = s_var_r != DMAC_V_LONG_UNSH;
  // RQ16 wide keyword; local wide mode, stored setting untouched
  wire m40_eff = ctrl_r.wide_overflow_mode || s_instr_r.wide_kw;
  wire dmac_lane_t lane_y = mac_lane(acc_y_r, shift_y, a_hi, b_hi, ctrl_r, s_instr_r.rnd, m40_eff);
  wire dmac_lane_t lane_x = mac_lane(acc_x_r, shift_x, a_lo, b_lo, ctrl_r, s_instr_r.rnd, m40_eff);

  // next values
  wire [15:0] data_step = issue_long ? DMAC_STEP_LONG : DMAC_STEP_SHORT;
  wire [15:0] pd_nxt = ptr_data_r - data_step;
  wire [15:0] pc_nxt = ptr_coef_r + DMAC_STEP_COEF;
  wire clr_x = reg_wr && sel_stat && reg_wdata[DMAC_STAT_FLAG_X];
  wire clr_y = reg_wr && sel_stat && reg_wdata[DMAC_STAT_FLAG_Y];
  wire flag_x_nxt = (flag_x_r && !clr_x) || (mem_rd_r && lane_x.ovf);
  wire flag_y_nxt = (flag_y_r && !clr_y) || (mem_rd_r && lane_y.ovf);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= '0;
      rdata_r <= 32'h00000000;
    end else begin
      if (reg_wr && sel_ctrl) begin
        ctrl_r <= reg_wdata[4:0];
      end
      rdata_r <= reg_rd ? rd_mux : 32'h00000000;
    end
  end

  // address generation, step to the next operand pair
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_data_r <= DMAC_PTR_RST;
      ptr_coef_r <= DMAC_PTR_RST;
      addr_r <= '0;
      mem_rd_r <= 1'b0;
      s_instr_r <= '0;
      s_var_r <= DMAC_V_NONE;
    end else begin
      mem_rd_r <= issue_go;
      if (issue_go) begin
        // high words at the pointer, low words at the partner; the single word form reads its data low word at the pointer
        addr_r.x_hi <= ptr_data_r;
        addr_r.x_lo <= issue_long ? partner(ptr_data_r) : ptr_data_r;
        addr_r.c_hi <= ptr_coef_r;
        addr_r.c_lo <= partner(ptr_coef_r);
        s_instr_r <= instr;
        s_var_r <= issue_var;
      end
      // post-modify by two for long, one for single word
      if (issue_go && instr.data_post_dec) begin
        ptr_data_r <= pd_nxt;
      end else if (reg_wr && sel_pd) begin
        ptr_data_r <= reg_wdata[15:0];
      end
      // coefficient post-increment
      if (issue_go && instr.coef_post_inc) begin
        ptr_coef_r <= pc_nxt;
      end else if (reg_wr && sel_pc) begin
        ptr_coef_r <= reg_wdata[15:0];
      end
    end
  end

  // both units write back in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_x_r <= DMAC_ACC_RST;
      acc_y_r <= DMAC_ACC_RST;
      done_r <= 1'b0;
    end else begin
      done_r <= mem_rd_r;
      // datapath beats a colliding software load
      if (mem_rd_r) begin
        acc_x_r <= lane_x.acc;
        acc_y_r <= lane_y.acc;
      end else begin
        if (reg_wr && sel_ax_lo) begin
          acc_x_r[31:0] <= reg_wdata;
        end
        if (reg_wr && sel_ax_hi) begin
          acc_x_r[39:32] <= reg_wdata[7:0];
        end
        if (reg_wr && sel_ay_lo) begin
          acc_y_r[31:0] <= reg_wdata;
        end
        if (reg_wr && sel_ay_hi) begin
          acc_y_r[39:32] <= reg_wdata[7:0];
        end
      end
    end
  end

  // sticky overflow flags, set beats clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_x_r <= 1'b0;
      flag_y_r <= 1'b0;
    end else begin
      flag_x_r <= flag_x_nxt;
      flag_y_r <= flag_y_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign instr_done = done_r;
  assign mem_rd = mem_rd_r;
  assign mem_addr = addr_r;
  assign acc_overflow_flag_x = flag_x_r;
  assign acc_overflow_flag_y = flag_y_r;

  AST_ONE_CYCLE_PAIR: assert property (@(posedge clk) disable iff (sys_rst) // RQ1
    issue_go |=> mem_rd ##1 instr_done)
    else $error("dual mac did not complete two cycles after issue");

  AST_DECODE_UNSH: assert property (@(posedge clk) disable iff (sys_rst) // RQ2
    (instr_valid && instr.op_word[15:10] == 6'h15) |=> s_var_r == DMAC_V_LONG_UNSH && mem_rd)
    else $error("unshifted long form not decoded");

  AST_DECODE_MIX: assert property (@(posedge clk) disable iff (sys_rst) // RQ3
    (instr_valid && instr.op_word[15:10] == 6'h18) |=> s_var_r == DMAC_V_LONG_MIX && mem_rd)
    else $error("mixed long form not decoded");

  AST_PARTNER_ADDR: assert property (@(posedge clk) disable iff (sys_rst) // RQ6
    (mem_rd && s_long) |-> mem_addr.x_lo == (mem_addr.x_hi ^ 16'h0001) &&
      mem_addr.c_lo == (mem_addr.c_hi ^ 16'h0001))
    else $error("low word not fetched from partner address");

  AST_HIGH_ADDR: assert property (@(posedge clk) disable iff (sys_rst) // RQ4
    issue_go |=> mem_addr.x_hi == $past(ptr_data_r) && mem_addr.c_hi == $past(ptr_coef_r))
    else $error("high words not fetched at effective address");

  AST_LONG_DEC: assert property (@(posedge clk) disable iff (sys_rst) // RQ19
    (issue_go && issue_long && instr.data_post_dec) |=>
      ptr_data_r == $past(ptr_data_r) - 16'h0002)
    else $error("long data pointer not decremented by two");

  AST_SHORT_DEC: assert property (@(posedge clk) disable iff (sys_rst) // RQ21
    (issue_go && !issue_long && instr.data_post_dec) |=>
      ptr_data_r == $past(ptr_data_r) - 16'h0001)
    else $error("single word data pointer not decremented by one");

  AST_COEF_INC: assert property (@(posedge clk) disable iff (sys_rst) // RQ20
    (issue_go && instr.coef_post_inc) |=> ptr_coef_r == $past(ptr_coef_r) + 16'h0002)
    else $error("coefficient pointer not incremented by two");

  AST_FLAG_SET: assert property (@(posedge clk) disable iff (sys_rst) // RQ14
    (mem_rd && (lane_x.ovf || lane_y.ovf)) |=>
      (acc_overflow_flag_x || !$past(lane_x.ovf)) && (acc_overflow_flag_y || !$past(lane_y.ovf)))
    else $error("overflow flag not set on overflow");

  AST_SAT32: assert property (@(posedge clk) disable iff (sys_rst) // RQ15
    (mem_rd && lane_x.ovf && ctrl_r.datapath_saturation_enable && !m40_eff) |=>
      acc_x_r == 40'h007fffffff || acc_x_r == 40'hff80000000)
    else $error("acc_x not saturated to 32-bit limit");

  AST_WIDE_LOCAL: assert property (@(posedge clk) disable iff (sys_rst) // RQ16
    (issue_go && instr.wide_kw && !(reg_wr && sel_ctrl)) |=> $stable(ctrl_r))
    else $error("wide keyword altered stored mode");

  AST_MIX_SHIFT: assert property (@(posedge clk) disable iff (sys_rst) // RQ12
    (mem_rd && s_var_r == DMAC_V_LONG_MIX && !s_instr_r.rnd && !lane_x.ovf &&
      b_lo == 17'h00000) |=>
      acc_x_r == {{16{$past(acc_x_r[39])}}, $past(acc_x_r[39:16])})
    else $error("acc_x not arithmetically shifted by 16");

endmodule
`default_nettype wire

// File: test/dmac_mem_model.sv
// memory partner model: data and coefficient words on the four read buses
`timescale 1ns/1ps
`default_nettype none
module dmac_mem_model
  import dmac_pkg::*;
(
  // clock
  input wire logic clk,
  // request
  input wire logic mem_rd,
  input wire dmac_addr_t mem_addr,
  // read data
  output logic [15:0] long_read_bus_c,
  output logic [15:0] read_bus_d,
  output logic [15:0] coef_bus_high,
  output logic [15:0] coef_bus_low
);
  logic [15:0] dmem [256];
  logic [15:0] cmem [256];
  logic [15:0] junk_r = 16'h5a3c;
  // idle buses churn so a stale word never passes for data
  always @(posedge clk) junk_r <= {junk_r[14:0], junk_r[15] ^ junk_r[13]};
  always_comb begin
    long_read_bus_c = mem_rd ? dmem[mem_addr.x_hi[7:0]] : junk_r;
    read_bus_d = mem_rd ? dmem[mem_addr.x_lo[7:0]] : ~junk_r;
    coef_bus_high = mem_rd ? cmem[mem_addr.c_hi[7:0]] : {junk_r[7:0], junk_r[15:8]};
    coef_bus_low = mem_rd ? cmem[mem_addr.c_lo[7:0]] : ~{junk_r[7:0], junk_r[15:8]};
  end
endmodule
`default_nettype wire

// File: test/dual_mac_long_operand_bench.sv
// self-checking bench of the dual long-operand mac datapath
`timescale 1ns/1ps
`default_nettype none
module dual_mac_long_operand_bench
  import dmac_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic instr_valid = 1'b0;
  dmac_instr_t instr = '0;
  logic instr_done, mem_rd, rd_q;
  dmac_addr_t mem_addr;
  logic [15:0] long_read_bus_c, read_bus_d, coef_bus_high, coef_bus_low;
  logic acc_overflow_flag_x, acc_overflow_flag_y;
  int mismatches = 0, checked = 0, dones = 0, issued = 0;
  logic [31:0] seed = 32'h80b6f61a;
  logic [39:0] ax, ay;
  logic [15:0] pd, pc;
  dmac_ctrl_t ct;
  logic fx, fy;
  dmac_addr_t aq[$];
  logic [5:0] pats [6] = '{DMAC_PAT_LONG_UNSH, DMAC_PAT_LONG_MIX, DMAC_PAT_LONG_BOTH,
    DMAC_PAT_SHORT_MIX, DMAC_PAT_SHORT_BOTH, 6'h3f};
  dmac_core dut_u (.*);
  dmac_mem_model mem_u (.*);
  always #20 clk = ~clk;
  function automatic logic [31:0] rnd32();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wrap_up();
    if (mismatches == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic note(input bit ok, input logic [63:0] g, e);
    checked++;
    if (!ok) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_reg(input logic [31:0] g, e);
    note(g === e, {32'h0, g}, {32'h0, e});
  endtask
  task automatic cmp_addr(input dmac_addr_t g, e);
    note(g === e, g, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 cmp_reg(reg_rdata, e);
    @(posedge clk);
  endtask
  // reference lane: extend, multiply, pre-shift, add, round, overflow, saturate
  function automatic logic [39:0] lane(input logic [39:0] a, input bit pre,
      input logic [15:0] m, c, input dmac_instr_t i, output logic ov);
    logic signed [16:0] ea, eb;
    logic signed [33:0] p;
    logic [31:0] p32;
    logic [40:0] s;
    bit tie, wide;
    ea = i.uns_mem ? {1'b0, m} : {m[15], m};
    eb = i.uns_coef ? {1'b0, c} : {c[15], c};
    p = ea * eb;
    p32 = ct.fractional_mode ? {p[30:0], 1'b0} : p[31:0];
    if (ct.fractional_mode && ct.multiply_saturation_mode && ea == DMAC_MIN17 && eb == DMAC_MIN17)
      p32 = DMAC_PROD_SAT;
    s = pre ? {{17{a[39]}}, a[39:16]} : {a[39], a};
    s = s + {{9{p32[31]}}, p32};
    if (i.rnd) begin
      tie = s[15:0] == DMAC_RND_HALF;
      s = s + DMAC_RND_ADD;
      s[15:0] = 16'h0;
      if (ct.rounding_mode_select && tie)
        s[16] = 1'b0;
    end
    wide = ct.wide_overflow_mode | i.wide_kw;
    ov = wide ? s[40] != s[39] : !(s[40:31] == '0 || s[40:31] == '1);
    if (ov && ct.datapath_saturation_enable)
      return s[40] ? (wide ? DMAC_SAT40_NEG : DMAC_SAT32_NEG) :
        (wide ? DMAC_SAT40_POS : DMAC_SAT32_POS);
    return s[39:0];
  endfunction
  task automatic issue(input dmac_instr_t i);
    logic [5:0] f;
    logic ox, oy;
    bit lng;
    f = i.op_word[15:10];
    lng = f[4];
    instr <= i;
    instr_valid <= 1'b1;
    @(posedge clk);
    if (f == pats[5])
      return;
    aq.push_back({pd, lng ? pd ^ 16'h1 : pd, pc, pc ^ 16'h1});
    ay = lane(ay, f[1:0] == 2'b11, mem_u.dmem[pd[7:0]], mem_u.cmem[pc[7:0]], i, oy);
    ax = lane(ax, f != DMAC_PAT_LONG_UNSH, mem_u.dmem[lng ? pd[7:0] ^ 8'h1 : pd[7:0]],
      mem_u.cmem[pc[7:0] ^ 8'h1], i, ox);
    fx |= ox;
    fy |= oy;
    if (i.data_post_dec)
      pd -= lng ? DMAC_STEP_LONG : DMAC_STEP_SHORT;
    if (i.coef_post_inc)
      pc += DMAC_STEP_COEF;
    issued++;
  endtask
  // address of every read and the one-cycle result slot
  always @(negedge clk) begin
    if (mem_rd === 1'b1)
      cmp_addr(mem_addr, aq.pop_front());
    if (!sys_rst)
      cmp_reg({31'h0, instr_done}, {31'h0, rd_q});
    if (instr_done === 1'b1)
      dones++;
    rd_q = mem_rd === 1'b1;
  end
  initial begin
    #1000000;
    mismatches++;
    wrap_up();
  end
  initial begin
    logic [31:0] v;
    dmac_instr_t i;
    int n;
    rd_q = 1'b0;
    fx = 1'b0;
    fy = 1'b0;
    for (int a = 0; a < 256; a++) begin
      v = rnd32();
      mem_u.dmem[a] = a < 4 ? 16'h8000 : v[15:0];
      mem_u.cmem[a] = a < 4 ? 16'h8000 : v[31:16];
    end
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    wr(8'h24, 32'hffffffff);
    for (int a = 0; a <= 36; a += 4)
      chk(a[7:0], 32'h0);
    for (int r = 0; r < 200; r++) begin
      v = rnd32();
      ct = v[4:0];
      pd = r % 8 == 0 ? 16'h0002 : v[31:16];
      pc = r % 8 == 0 ? 16'h0000 : v[15:0];
      v = rnd32();
      ax = {v[7:0], rnd32()};
      ay = {v[15:8], rnd32()};
      wr(DMAC_REG_CTRL, {27'h0, ct});
      wr(DMAC_REG_PTR_DATA, {16'h0, pd});
      wr(DMAC_REG_PTR_COEF, {16'h0, pc});
      wr(DMAC_REG_ACCX_LO, ax[31:0]);
      wr(DMAC_REG_ACCX_HI, {24'h0, ax[39:32]});
      wr(DMAC_REG_ACCY_LO, ay[31:0]);
      wr(DMAC_REG_ACCY_HI, {24'h0, ay[39:32]});
      n = 1 + int'(rnd32() % 4);
      // back-to-back issue, repeat style
      for (int k = 0; k < n; k++) begin
        v = rnd32();
        i = {pats[v[30:28] % 6], v[25:10]};
        issue(i);
      end
      instr_valid <= 1'b0;
      repeat (3) @(posedge clk);
      chk(DMAC_REG_ACCX_LO, ax[31:0]);
      chk(DMAC_REG_ACCX_HI, {24'h0, ax[39:32]});
      chk(DMAC_REG_ACCY_LO, ay[31:0]);
      chk(DMAC_REG_ACCY_HI, {24'h0, ay[39:32]});
      chk(DMAC_REG_PTR_DATA, {16'h0, pd});
      chk(DMAC_REG_PTR_COEF, {16'h0, pc});
      chk(DMAC_REG_STAT, {30'h0, fy, fx});
      cmp_reg({30'h0, acc_overflow_flag_y, acc_overflow_flag_x}, {30'h0, fy, fx});
      wr(DMAC_REG_STAT, 32'h3);
      fx = 1'b0;
      fy = 1'b0;
    end
    cmp_reg(dones, issued);
    cmp_reg(aq.size(), 0);
    wrap_up();
  end
endmodule
`default_nettype wire
